// ### logic/lin_uart_ctl.v
// lin uart control: noise filter, lin state machine, autobaud, break, axi4-lite slave
`include "lin_uart_ctl_defines.vh"
module lin_uart_ctl #(
	parameter [15:0] BIT_PERIOD_RST = `RST_BITPER
) (
	input  wire        clk,
	input  wire        rst,
	input  wire [31:0] awaddr,
	input  wire [2:0]  awprot,
	input  wire        awvalid,
	output wire        awready,
	input  wire [31:0] wdata,
	input  wire [3:0]  wstrb,
	input  wire        wvalid,
	output wire        wready,
	output wire [1:0]  bresp,
	output wire        bvalid,
	input  wire        bready,
	input  wire [31:0] araddr,
	input  wire [2:0]  arprot,
	input  wire        arvalid,
	output wire        arready,
	output wire [31:0] rdata,
	output wire [1:0]  rresp,
	output wire        rvalid,
	input  wire        rready,
	input  wire        rxIn,
	output wire        rxFiltered,
	output wire        txOut,
	output wire        linMaster,
	output wire        linSlave,
	output wire        nineBitFraming,
	output wire        parityOn,
	output wire [7:0]  otherCtl,
	output wire        irq
);
	localparam [2:0] DET_IDLE = 3'h1;
	localparam [2:0] DET_LOW  = 3'h2;
	localparam [2:0] DET_SYNC = 3'h4;

	localparam [2:0] SEL_NONE   = 3'h0;
	localparam [2:0] SEL_CTL1   = 3'h1;
	localparam [2:0] SEL_VIEW   = 3'h2;
	localparam [2:0] SEL_STATUS = 3'h3;
	localparam [2:0] SEL_MASK   = 3'h4;
	localparam [2:0] SEL_BITPER = 3'h5;

	// one select alone, and no framing option that lin cannot carry
	function modeQual;
		input sel;
		input other;
		input nine;
		input par;
		begin
			modeQual = sel & ~other & ~nine & ~par;
		end
	endfunction

	// counter span for a width code: 4 bits at code 0 up to 11 bits at code 7
	function [10:0] filtSpan;
		input [2:0] code;
		begin
			filtSpan = 11'h7ff >> (3'h7 - code);
		end
	endfunction

	function [2:0] regSel;
		input [31:0] a;
		begin
			case (a[31:2])
				`IDX_CTL1:   regSel = SEL_CTL1;
				`IDX_VIEW:   regSel = SEL_VIEW;
				`IDX_STATUS: regSel = SEL_STATUS;
				`IDX_MASK:   regSel = SEL_MASK;
				`IDX_BITPER: regSel = SEL_BITPER;
				default:     regSel = SEL_NONE;
			endcase
		end
	endfunction

	reg        bvalid_ff;
	reg [1:0]  bresp_ff;
	reg        rvalid_ff;
	reg [1:0]  rresp_ff;
	reg [31:0] rdata_ff;
	reg [2:0]  view_ff;
	reg        nineBit_ff;
	reg        parity_ff;
	reg        filtEn_ff;
	reg        filtSpare_ff;
	reg [2:0]  filtCode_ff;
	reg        lin_master_select_ff;
	reg        lin_slave_select_ff;
	reg        autobaud_enable_bit_ff;
	reg        autobaud_irq_enable_ff;
	reg [1:0]  lin_state_field_ff;
	reg [1:0]  brkLen_ff;
	reg [7:0]  other_ff;
	reg [2:0]  status_ff;
	reg [2:0]  mask_ff;
	reg [15:0] bitPer_ff;
	reg [10:0] filtCnt_ff;
	reg        filtOut_ff;
	reg        rxUse_ff;
	reg        rxPrev_ff;
	reg [2:0]  det_ff;
	reg [23:0] detCnt_ff;
	reg [2:0]  falls_ff;
	reg [20:0] brkCnt_ff;
	reg        txOut_ff;

	wire       wrFire = awvalid & wvalid & ~bvalid_ff;
	wire       rdFire = arvalid & ~rvalid_ff;
	wire [2:0] wSel   = regSel(awaddr);
	wire [2:0] rSel   = regSel(araddr);
	wire       wb0    = wrFire & wstrb[0];
	wire       wrCtl1 = wb0 & (wSel == SEL_CTL1);
	wire       wrLin  = wrCtl1 & (view_ff == `VIEW_LIN);
	wire       wrFilt = wrCtl1 & (view_ff == `VIEW_FILTER);
	wire       wrView = wb0 & (wSel == SEL_VIEW);

	assign awready = wrFire;
	assign wready  = wrFire;
	assign bvalid  = bvalid_ff;
	assign bresp   = bresp_ff;
	assign arready = rdFire;
	assign rvalid  = rvalid_ff;
	assign rresp   = rresp_ff;
	assign rdata   = rdata_ff;

	// mode qualification: each select needs the other and both framing options clear
	assign linMaster      = modeQual(lin_master_select_ff, lin_slave_select_ff, nineBit_ff, parity_ff);
	assign linSlave       = modeQual(lin_slave_select_ff, lin_master_select_ff, nineBit_ff, parity_ff);
	assign nineBitFraming = nineBit_ff;
	assign parityOn       = parity_ff;
	assign otherCtl       = other_ff;
	assign rxFiltered     = rxUse_ff;
	assign txOut          = txOut_ff;
	assign irq            = |(status_ff & mask_ff);

	// ctl1 read view follows the view code
	reg [7:0] ctl1Rd;
	always @* begin
		case (view_ff)
			`VIEW_FILTER: ctl1Rd = {filtEn_ff, filtSpare_ff, filtCode_ff, 3'h0};
			`VIEW_LIN:    ctl1Rd = {lin_master_select_ff, lin_slave_select_ff, autobaud_enable_bit_ff, autobaud_irq_enable_ff,
				lin_state_field_ff, brkLen_ff};
			default:      ctl1Rd = other_ff;
		endcase
	end

	reg [31:0] rdMux;
	always @* begin
		case (rSel)
			SEL_CTL1:   rdMux = {24'h000000, ctl1Rd};
			SEL_VIEW:   rdMux = {27'h0000000, parity_ff, nineBit_ff, view_ff};
			SEL_STATUS: rdMux = {29'h00000000, status_ff};
			SEL_MASK:   rdMux = {29'h00000000, mask_ff};
			SEL_BITPER: rdMux = {16'h0000, bitPer_ff};
			default:    rdMux = 32'h00000000;
		endcase
	end

	// axi write response channel
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= `RESP_OKAY;
		end else if (wrFire) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= (wSel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
		end else if (bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// axi read data channel; rdata is captured at the take and held
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rvalid_ff <= 1'b0;
			rresp_ff  <= `RESP_OKAY;
			rdata_ff  <= 32'h00000000;
		end else if (rdFire) begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= (rSel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
			rdata_ff  <= rdMux;
		end else if (rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// configuration registers
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			view_ff      <= `RST_VIEW;
			nineBit_ff   <= 1'b0;
			parity_ff    <= 1'b0;
			filtEn_ff    <= 1'b0;
			filtSpare_ff <= 1'b0;
			filtCode_ff  <= 3'h0;
			lin_master_select_ff      <= 1'b0;
			lin_slave_select_ff      <= 1'b0;
			autobaud_enable_bit_ff      <= 1'b0;
			autobaud_irq_enable_ff     <= 1'b0;
			brkLen_ff    <= 2'h0;
			other_ff     <= `RST_BYTE;
			mask_ff      <= 3'h0;
		end else begin
			if (wrView) begin
				view_ff    <= wdata[`VW_SEL_LSB +: 3];
				nineBit_ff <= wdata[`VW_NINEBIT];
				parity_ff  <= wdata[`VW_PARITY];
			end
			if (wrFilt) begin
				filtEn_ff    <= wdata[`NF_EN];
				filtSpare_ff <= wdata[`NF_SPARE];
				filtCode_ff  <= wdata[`NF_CODE_LSB +: 3];
			end
			if (wrLin) begin
				lin_master_select_ff   <= wdata[`LIN_MST];
				lin_slave_select_ff   <= wdata[`LIN_SLV];
				autobaud_enable_bit_ff   <= wdata[`LIN_AUTOBAUD_ENABLE_BIT];
				autobaud_irq_enable_ff  <= wdata[`LIN_AUTOBAUD_IRQ_ENABLE];
				brkLen_ff <= wdata[`LIN_BL_LSB +: 2];
			end
			if (wrCtl1 && view_ff != `VIEW_FILTER && view_ff != `VIEW_LIN)
				other_ff <= wdata[7:0];
			if (wb0 && wSel == SEL_MASK)
				mask_ff <= wdata[2:0];
		end
	end

	// noise filter: saturating up/down counter, output flips only at the rails
	wire [10:0] fMax = filtSpan(filtCode_ff);
	always @(posedge clk or posedge rst) begin
		if (rst)
			filtCnt_ff <= 11'h7ff;
		else if (filtCnt_ff > fMax)
			filtCnt_ff <= fMax;
		else if (rxIn && filtCnt_ff != fMax)
			filtCnt_ff <= filtCnt_ff + 11'h001;
		else if (!rxIn && filtCnt_ff != 11'h000)
			filtCnt_ff <= filtCnt_ff - 11'h001;
	end

	// a glitch must outlast the whole span to flip the output
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			filtOut_ff <= 1'b1;
			rxUse_ff   <= 1'b1;
			rxPrev_ff  <= 1'b1;
		end else begin
			if (filtCnt_ff == fMax)
				filtOut_ff <= 1'b1;
			else if (filtCnt_ff == 11'h000)
				filtOut_ff <= 1'b0;
			rxUse_ff  <= filtEn_ff ? filtOut_ff : rxIn;
			rxPrev_ff <= rxUse_ff;
		end
	end

	// break detection and sync measurement for the slave
	wire [19:0] brkThresh = {4'h0, bitPer_ff} * {16'h0000, `BRK_DET_BITS};
	wire        fallEdge  = rxPrev_ff & ~rxUse_ff;
	wire        stateOk   = (lin_state_field_ff == `ST_WAITBRK) || (lin_state_field_ff == `ST_AUTOBAUD);
	reg  [2:0]  nxt_det;
	reg  [1:0]  nxt_lin_state_field;
	reg         brkSeen;
	reg         abDone;
	always @* begin
		nxt_det      = det_ff;
		nxt_lin_state_field = lin_state_field_ff;
		brkSeen      = 1'b0;
		abDone       = 1'b0;
		case (det_ff)
			DET_IDLE: begin
				if (linSlave && lin_state_field_ff == `ST_WAITBRK && !rxUse_ff)
					nxt_det = DET_LOW;
			end
			DET_LOW: begin
				if (rxUse_ff) begin
					nxt_det = DET_IDLE;
					if (detCnt_ff >= {4'h0, brkThresh}) begin
						brkSeen = 1'b1;
						if (autobaud_enable_bit_ff) begin
							nxt_lin_state_field = `ST_AUTOBAUD;
							nxt_det      = DET_SYNC;
						end else
							nxt_lin_state_field = `ST_ACTIVE;
					end
				end
			end
			DET_SYNC: begin
				if (fallEdge && falls_ff == `SYNC_FALLS) begin
					abDone       = 1'b1;
					nxt_lin_state_field = `ST_ACTIVE;
					nxt_det      = DET_IDLE;
				end
			end
			default: nxt_det = DET_IDLE;
		endcase
		// leaving slave mode or a software move to sleep or active aborts the sequence
		if (!linSlave || !stateOk)
			nxt_det = DET_IDLE;
		// a software write always wins, master included
		if (wrLin)
			nxt_lin_state_field = wdata[`LIN_ST_LSB +: 2];
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			det_ff      <= DET_IDLE;
			detCnt_ff   <= 24'h000000;
			falls_ff    <= 3'h0;
			lin_state_field_ff <= `ST_SLEEP;
			bitPer_ff   <= BIT_PERIOD_RST;
		end else begin
			det_ff      <= nxt_det;
			lin_state_field_ff <= nxt_lin_state_field;
			if (nxt_det != det_ff) begin
				detCnt_ff <= 24'h000001;
				falls_ff  <= 3'h0;
			end else if (det_ff == DET_SYNC && fallEdge && falls_ff == 3'h0) begin
				detCnt_ff <= 24'h000001;
				falls_ff  <= 3'h1;
			end else begin
				if (detCnt_ff != 24'hffffff)
					detCnt_ff <= detCnt_ff + 24'h000001;
				if (fallEdge)
					falls_ff <= falls_ff + 3'h1;
			end
			// sync byte spans eight bit times between first and fifth fall
			if (abDone)
				bitPer_ff <= detCnt_ff[18:3];
			else if (wrFire && wSel == SEL_BITPER) begin
				if (wstrb[0])
					bitPer_ff[7:0] <= wdata[7:0];
				if (wstrb[1])
					bitPer_ff[15:8] <= wdata[15:8];
			end
		end
	end

	// master break transmit, started from the view register
	wire        brkGo   = wrView & wdata[`VW_BRKGO] & linMaster &
		(lin_state_field_ff == `ST_ACTIVE) & (brkCnt_ff == 21'h000000);
	wire [7:0]  brkBits = {3'h0, `BRK_TX_BASE} + {6'h00, brkLen_ff};
	wire [20:0] brkLoad = {13'h0000, brkBits} * {5'h00, bitPer_ff};
	wire        brkEnd  = (brkCnt_ff == 21'h000001);
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			brkCnt_ff <= 21'h000000;
			txOut_ff  <= 1'b1;
		end else begin
			if (brkGo)
				brkCnt_ff <= brkLoad;
			else if (brkCnt_ff != 21'h000000)
				brkCnt_ff <= brkCnt_ff - 21'h000001;
			txOut_ff <= ~(brkGo | (brkCnt_ff > 21'h000001));
		end
	end

	// sticky status, cleared by reading; a new event in the read cycle survives
	wire [2:0] evSet = {brkEnd, brkSeen, abDone & autobaud_irq_enable_ff & linSlave};
	wire       stClr = rdFire & (rSel == SEL_STATUS);
	wire [2:0] nxt_status;
	genvar     sb;
	generate
		for (sb = 0; sb < 3; sb = sb + 1) begin : g_status
			assign nxt_status[sb] = evSet[sb] | (status_ff[sb] & ~stClr);
		end
	endgenerate
	always @(posedge clk or posedge rst) begin
		if (rst)
			status_ff <= 3'h0;
		else
			status_ff <= nxt_status;
	end
endmodule // lin_uart_ctl

// ### logic/lin_uart_ctl_defines.vh
// offsets, field positions, reset values and counts for the lin uart control block
`ifndef LIN_UART_CTL_DEFINES_VH
`define LIN_UART_CTL_DEFINES_VH
// register indices, byte address is four times the index
`define IDX_CTL1      30'h00ffe203
`define IDX_VIEW      30'h00ffe20c
`define IDX_STATUS    30'h00ffe20d
`define IDX_MASK      30'h00ffe20e
`define IDX_BITPER    30'h00ffe20f
// view codes
`define VIEW_FILTER   3'h1
`define VIEW_LIN      3'h2
// view register fields
`define VW_SEL_LSB    0
`define VW_NINEBIT    3
`define VW_PARITY     4
`define VW_BRKGO      5
// lin view fields
`define LIN_MST       7
`define LIN_SLV       6
`define LIN_AUTOBAUD_ENABLE_BIT      5
`define LIN_AUTOBAUD_IRQ_ENABLE     4
`define LIN_ST_LSB    2
`define LIN_BL_LSB    0
// filter view fields
`define NF_EN         7
`define NF_SPARE      6
`define NF_CODE_LSB   3
// lin states
`define ST_SLEEP      2'h0
`define ST_WAITBRK    2'h1
`define ST_AUTOBAUD   2'h2
`define ST_ACTIVE     2'h3
// status bits
`define SB_ABDONE     0
`define SB_BRKDET     1
`define SB_BRKSENT    2
// reset values and counts
`define RST_BYTE      8'h00
`define RST_VIEW      3'h0
`define RST_BITPER    16'h0400
`define BRK_DET_BITS  4'hb
`define BRK_TX_BASE   5'hd
`define SYNC_FALLS    3'h4
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

// ### verif/lin_bus_node.sv
// far lin node model: break plus sync byte on the receive line
module lin_bus_node (
	input  wire        clk,
	input  wire        go,
	input  wire [15:0] brk,
	input  wire [15:0] bt,
	output reg         rxLine
);
	timeunit 1ns;
	timeprecision 1ns;
	reg [9:0] frame;
	integer   i;
	// bus pull-up keeps the line high between frames
	initial rxLine = 1'b1;
	always @(posedge clk) begin
		if (go) begin
			rxLine <= 1'b0;
			repeat (brk) @(posedge clk);
			rxLine <= 1'b1;
			// zero bit time means a bare break or glitch
			if (bt != 16'h0000) begin
				repeat (bt) @(posedge clk);
				frame = {1'b1, 8'h55, 1'b0};
				for (i = 0; i < 10; i++) begin
					rxLine <= frame[i];
					repeat (bt) @(posedge clk);
				end
			end
		end
	end
endmodule // lin_bus_node

// ### verif/lin_uart_ctl_checker.sv
// port-level assertions for the lin uart control block
module lin_uart_ctl_checker (
	input wire        clk,
	input wire        rst,
	input wire        awvalid,
	input wire        wvalid,
	input wire        awready,
	input wire        bvalid,
	input wire        bready,
	input wire [1:0]  bresp,
	input wire        arvalid,
	input wire        arready,
	input wire        rvalid,
	input wire        rready,
	input wire [31:0] rdata,
	input wire        txOut,
	input wire        linMaster,
	input wire        linSlave,
	input wire        nineBitFraming,
	input wire        parityOn
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence wrTake;
		awvalid && wvalid && awready;
	endsequence
	sequence rdTake;
		arvalid && arready;
	endsequence
	wr_answer_a: assert property (wrTake |=> bvalid) else $error("write not answered");
	rd_answer_a: assert property (rdTake |=> rvalid) else $error("read not answered");
	b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped");
	mode_excl_a: assert property (linMaster |-> !linSlave)
		else $error("both lin modes on");
	master_qual_a: assert property (linMaster |-> !nineBitFraming && !parityOn)
		else $error("master with framing on");
	slave_qual_a: assert property (linSlave |-> !(nineBitFraming || parityOn))
		else $error("slave with framing on");
	// a break is at least 13 bit times, so at least eight cycles
	break_len_a: assert property ($fell(txOut) |-> linMaster ##0 (!txOut)[*8])
		else $error("short or stray break");
endmodule // lin_uart_ctl_checker
bind lin_uart_ctl lin_uart_ctl_checker lin_uart_ctl_checker_i (
	.clk(clk),
	.rst(rst),
	.awvalid(awvalid),
	.wvalid(wvalid),
	.awready(awready),
	.bvalid(bvalid),
	.bready(bready),
	.bresp(bresp),
	.arvalid(arvalid),
	.arready(arready),
	.rvalid(rvalid),
	.rready(rready),
	.rdata(rdata),
	.txOut(txOut),
	.linMaster(linMaster),
	.linSlave(linSlave),
	.nineBitFraming(nineBitFraming),
	.parityOn(parityOn)
);

// ### verif/lin_uart_ctl_tb.sv
// self-checking bench for the lin uart control block
`include "lin_uart_ctl_defines.vh"
module lin_uart_ctl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam [29:0] CT = `IDX_CTL1, VW = `IDX_VIEW, ST = `IDX_STATUS;
	localparam [29:0] MK = `IDX_MASK, BP = `IDX_BITPER;
	reg         clk, rst, awvalid, wvalid, bready, arvalid, rready, go;
	reg  [31:0] awaddr, wdata, araddr, v;
	reg  [15:0] brk, bt;
	wire        awready, wready, bvalid, arready, rvalid, rxIn, rxFiltered, txOut;
	wire        linMaster, linSlave, nineBitFraming, parityOn, irq;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata;
	wire [7:0]  otherCtl;
	integer     failures, samples_checked, i, c, k, m, d;
	integer     lows = 0, run = 0, lastRun = 0;
	lin_uart_ctl #(.BIT_PERIOD_RST(16'h0010)) lin_uart_ctl_i (
		.clk(clk), .rst(rst), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .rxIn(rxIn), .rxFiltered(rxFiltered),
		.txOut(txOut), .linMaster(linMaster), .linSlave(linSlave),
		.nineBitFraming(nineBitFraming), .parityOn(parityOn), .otherCtl(otherCtl),
		.irq(irq));
	lin_bus_node lin_bus_node_i (.clk(clk), .go(go), .brk(brk), .bt(bt), .rxLine(rxIn));
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	// low-cycle counts of the filtered line and length of the last break
	always @(posedge clk) begin
		if (!rxFiltered) lows <= lows + 1;
		if (!txOut) run <= run + 1;
		else if (run > 0) begin
			lastRun <= run;
			run <= 0;
		end
	end
	task chk(input string s, input [31:0] e, input [31:0] g);
		samples_checked++;
		if (e !== g) begin
			failures++;
			$display("CHECK FAILED %s exp %h got %h", s, e, g);
		end
	endtask
	task close_out;
		$display("failures %0d checks %0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task tick(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task wr(input [29:0] a, input [15:0] x, input [1:0] er);
		integer n;
		awaddr <= {a, 2'h0};
		wdata <= {16'h0, x};
		{awvalid, wvalid} <= 2'h3;
		n = 0;
		do begin @(posedge clk); n++; end while (!awready && n < 99);
		chk("wready", 1, wready);
		{awvalid, wvalid} <= 2'h0;
		do begin @(posedge clk); n++; end while (!bvalid && n < 99);
		// late ready makes the slave hold its answer one cycle
		bready <= 1;
		@(posedge clk);
		bready <= 0;
		if (n >= 99) begin failures++; close_out; end
		chk("bresp", er, bresp);
	endtask
	task rd(input string s, input [29:0] a, input [1:0] er, input [31:0] e);
		integer n;
		araddr <= {a, 2'h0};
		arvalid <= 1;
		n = 0;
		do begin @(posedge clk); n++; end while (!arready && n < 99);
		arvalid <= 0;
		do begin @(posedge clk); n++; end while (!rvalid && n < 99);
		rready <= 1;
		@(posedge clk);
		rready <= 0;
		if (n >= 99) begin failures++; close_out; end
		v = rdata;
		chk("rresp", er, rresp);
		chk(s, e, v);
	endtask
	task pulse(input [15:0] b, input [15:0] t);
		brk <= b;
		bt <= t;
		go <= 1;
		@(posedge clk);
		go <= 0;
	endtask
	initial begin
		failures = 0;
		samples_checked = 0;
		{awvalid, wvalid, bready, arvalid, rready, go} = 6'h00;
		{awaddr, wdata, araddr, brk, bt} = 0;
		rst = 1;
		v = $urandom(32'hf4ef6b52);
		tick(12);
		rst <= 0;
		tick(1);
		rd("view", VW, 0, 0);
		rd("stat", ST, 0, 0);
		rd("mask", MK, 0, 0);
		rd("bitper", BP, 0, 16);
		rd("ctl1", CT, 0, 0);
		rd("hole", 0, 2, 0);
		wr(0, 1, 2);
		wr(VW, 1, 0);
		wr(CT, 16'hf8, 0);
		rd("filter", CT, 0, 32'hf8);
		wr(VW, 2, 0);
		rd("lin", CT, 0, 0);
		wr(VW, 0, 0);
		wr(CT, 16'h5a, 0);
		chk("other", 8'h5a, otherCtl);
		for (i = 0; i < 16; i++) begin
			wr(VW, {i[1:0], 3'h2}, 0);
			wr(CT, {i[3:2], 6'h0}, 0);
			chk("master", i == 8, linMaster);
			chk("slave", i == 4, linSlave);
			chk("nine", i[0], nineBitFraming);
			chk("parity", i[1], parityOn);
		end
		wr(VW, 1, 0);
		wr(CT, 0, 0);
		d = lows;
		pulse(1, 0);
		tick(5);
		chk("bypass", 1, lows - d);
		for (c = 0; c < 8; c++) begin
			m = (16 << c) - 1;
			wr(CT, {1'b1, 1'b0, c[2:0], 3'h0}, 0);
			tick(m + 9);
			k = $urandom_range(m - 1, 1);
			d = lows;
			pulse(k, 0);
			tick(k + m + 9);
			chk("short", 0, lows - d);
			d = lows;
			pulse(m + 1, 0);
			tick(2 * m + 9);
			chk("long", 1, lows > d);
		end
		wr(CT, 0, 0);
		wr(MK, 4, 0);
		for (c = 0; c < 4; c++) begin
			wr(VW, 2, 0);
			wr(CT, 8'h8c | c, 0);
			wr(VW, 16'h22, 0);
			tick((13 + c) * 16 + 9);
			chk("break", (13 + c) * 16, lastRun);
			chk("irq", 1, irq);
			rd("stat", ST, 0, 4);
			chk("irq", 0, irq);
			rd("ctl1", CT, 0, 8'h8c | c);
		end
		wr(MK, 1, 0);
		wr(CT, 8'h74, 0);
		pulse(312, 24);
		tick(320);
		rd("ctl1", CT, 0, 8'h78);
		tick(400);
		chk("irq", 1, irq);
		rd("stat", ST, 0, 3);
		rd("ctl1", CT, 0, 8'h7c);
		rd("bitper", BP, 0, 24);
		wr(CT, 8'h44, 0);
		pulse(312, 0);
		tick(330);
		rd("ctl1", CT, 0, 8'h4c);
		chk("irq", 0, irq);
		rd("stat", ST, 0, 2);
		wr(CT, 8'h40, 0);
		rd("ctl1", CT, 0, 8'h40);
		close_out;
	end
	initial begin
		tick(90000);
		failures++;
		close_out;
	end
endmodule // lin_uart_ctl_tb
